/* File: logic/dbdrs_pkg.sv */
// Shared constants and types of the diagnostic reset sequencer.
package dbdrs_pkg;

    // Sequencer states, one-hot.
    typedef enum logic [3:0] {
        ST_ACTIVE   = 4'h1,
        ST_RELEASED = 4'h2,
        ST_RESET    = 4'h4,
        ST_HOLD     = 4'h8
    } dbdrs_state_t;

    // Decoded interface condition of the three control lines.
    typedef enum logic [2:0] {
        IF_OTHER = 3'h1,
        IF_DIAG  = 3'h2,
        IF_SEL1  = 3'h4
    } dbdrs_ifstate_t;

    // Width of the synchronised input group.
    localparam int unsigned SYNC_W = 11;

    // Positions in the synchronised group.
    localparam int unsigned POS_SELECT = 0;
    localparam int unsigned POS_MASTER = 1;
    localparam int unsigned POS_STROBE = 2;
    localparam int unsigned POS_BUSA = 3;

    // Diagnostic data and enable bit positions on bus A, per lane.
    localparam logic [2:0] DATA_BIT0 = 3'h1;
    localparam logic [2:0] ENABLE_BIT0 = 3'h0;
    localparam logic [2:0] DATA_BIT1 = 3'h4;
    localparam logic [2:0] ENABLE_BIT1 = 3'h3;
    localparam logic [2:0] DATA_BIT2 = 3'h7;
    localparam logic [2:0] ENABLE_BIT2 = 3'h6;

    // Reset values.
    localparam dbdrs_state_t STATE_RESET_VALUE = ST_ACTIVE;
    localparam logic [SYNC_W-1:0] SYNC_RESET_VALUE = 11'h000;

endpackage : dbdrs_pkg

/* File: logic/dbdrs_pin_sync.sv */
// Three-stage input synchroniser with second and third stage agreement.
module dbdrs_pin_sync (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Raw pins and filtered result.
    input wire logic [dbdrs_pkg::SYNC_W-1:0] pinIn,
    output logic [dbdrs_pkg::SYNC_W-1:0] pinOut
);

    logic [dbdrs_pkg::SYNC_W-1:0] stage1_reg;
    logic [dbdrs_pkg::SYNC_W-1:0] stage2_reg;
    logic [dbdrs_pkg::SYNC_W-1:0] stage3_reg;

    ////////////////////////////////////////////////////////////////////////////

    // The first stage feeds only the second, so metastability cannot leak.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stage1_reg <= dbdrs_pkg::SYNC_RESET_VALUE;
            stage2_reg <= dbdrs_pkg::SYNC_RESET_VALUE;
            stage3_reg <= dbdrs_pkg::SYNC_RESET_VALUE;
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // A bit changes only once two later stages agree, masking single glitches.
    genvar gi;
    generate
        for (gi = 0; gi < dbdrs_pkg::SYNC_W; gi++) begin : gFilt
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    pinOut[gi] <= 1'b0;
                end else if (stage2_reg[gi] == stage3_reg[gi]) begin
                    pinOut[gi] <= stage3_reg[gi];
                end
            end
        end
    endgenerate

endmodule : dbdrs_pin_sync

/* File: logic/dbdrs_sequencer.sv */
// Slave-side diagnostic reset and driver release sequencer.
//
// Function
// [RULE1] On seeing the diagnostic entry state the slave releases its interface drivers.
// [RULE2] Diagnostic data active when the master strobe falls starts the internal reset.
// [RULE3] The internal reset ends as soon as the diagnostic data line is negated.
// [RULE4] After the reset the drivers stay released until the first selective-reset state.
// [RULE5] On seeing the first selective-reset state the slave enables its drivers again.
// [RULE6] The master drives both the diagnostic enable and data lines in this mode.
// [RULE7] The master enters diagnostics, asserts data, goes idle, then negates data.
module dbdrs_sequencer #(
    parameter logic [1:0] LANE = 2'h0
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Control lines from the master, active high.
    input wire logic selectOut,
    input wire logic masterOut,
    input wire logic syncOut,
    // Bus A from the master.
    input wire logic [7:0] busAOut,
    // Slave driver control and internal reset.
    output logic driversEnable,
    output logic diagReset,
    output logic diagBusy
);

    logic [dbdrs_pkg::SYNC_W-1:0] pinsFiltered;
    logic selectSeen;
    logic masterSeen;
    logic strobeSeen;
    logic strobe_reg;
    logic strobeFall;
    logic [7:0] busASeen;
    logic dataActive;
    dbdrs_pkg::dbdrs_ifstate_t ifState;
    dbdrs_pkg::dbdrs_state_t state_reg;
    dbdrs_pkg::dbdrs_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////

    dbdrs_pin_sync uSync (
        .clk_sys(clk_sys),
        .reset(reset),
        .pinIn({busAOut, syncOut, masterOut, selectOut}),
        .pinOut(pinsFiltered)
    );

    assign selectSeen = pinsFiltered[dbdrs_pkg::POS_SELECT];
    assign masterSeen = pinsFiltered[dbdrs_pkg::POS_MASTER];
    assign strobeSeen = pinsFiltered[dbdrs_pkg::POS_STROBE];
    assign busASeen = pinsFiltered[dbdrs_pkg::POS_BUSA +: 8];

    ////////////////////////////////////////////////////////////////////////////

    // Decode the control lines into the interface condition.
    function automatic dbdrs_pkg::dbdrs_ifstate_t decodeIf(
        input logic sel,
        input logic mst,
        input logic syn
    );
        if (!sel && !mst && syn) begin
            decodeIf = dbdrs_pkg::IF_DIAG;
        end else if (!sel && mst && syn) begin
            decodeIf = dbdrs_pkg::IF_SEL1;
        end else begin
            decodeIf = dbdrs_pkg::IF_OTHER;
        end
    endfunction : decodeIf

    // Data of the selected lane counts only while its enable is driven too.
    function automatic logic laneData(
        input logic [7:0] bus,
        input logic [1:0] lane
    );
        if (lane == 2'h2) begin
            laneData = bus[dbdrs_pkg::DATA_BIT2] && bus[dbdrs_pkg::ENABLE_BIT2]; // see [RULE6]
        end else if (lane == 2'h1) begin
            laneData = bus[dbdrs_pkg::DATA_BIT1] && bus[dbdrs_pkg::ENABLE_BIT1]; // see [RULE6]
        end else begin
            laneData = bus[dbdrs_pkg::DATA_BIT0] && bus[dbdrs_pkg::ENABLE_BIT0]; // see [RULE6]
        end
    endfunction : laneData

    assign ifState = decodeIf(selectSeen, masterSeen, strobeSeen);
    assign dataActive = laneData(busASeen, LANE);

    ////////////////////////////////////////////////////////////////////////////

    // Edge detector works on filtered data only, never the raw pin.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= strobeSeen;
        end
    end

    assign strobeFall = strobe_reg && !strobeSeen;

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dbdrs_pkg::ST_ACTIVE: begin
                if (ifState == dbdrs_pkg::IF_DIAG) begin
                    state_next = dbdrs_pkg::ST_RELEASED; // see [RULE1]
                end
            end
            dbdrs_pkg::ST_RELEASED: begin
                if (strobeFall && dataActive) begin
                    state_next = dbdrs_pkg::ST_RESET; // see [RULE2]
                end else if (ifState == dbdrs_pkg::IF_SEL1) begin
                    state_next = dbdrs_pkg::ST_ACTIVE; // see [RULE5]
                end
            end
            dbdrs_pkg::ST_RESET: begin
                if (!dataActive) begin
                    state_next = dbdrs_pkg::ST_HOLD; // see [RULE3]
                end
            end
            dbdrs_pkg::ST_HOLD: begin
                // Selective reset also needs the strobe, so an idle bus keeps drivers off.
                if (ifState == dbdrs_pkg::IF_SEL1) begin
                    state_next = dbdrs_pkg::ST_ACTIVE; // see [RULE4] [RULE5]
                end
            end
            default: begin
                state_next = dbdrs_pkg::STATE_RESET_VALUE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= dbdrs_pkg::STATE_RESET_VALUE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Outputs are registered so the pins never glitch during decoding.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            driversEnable <= 1'b1;
            diagReset <= 1'b0;
            diagBusy <= 1'b0;
        end else begin
            driversEnable <= (state_next == dbdrs_pkg::ST_ACTIVE); // see [RULE1] [RULE4]
            diagReset <= (state_next == dbdrs_pkg::ST_RESET); // see [RULE2] [RULE3]
            diagBusy <= (state_next != dbdrs_pkg::ST_ACTIVE);
        end
    end

endmodule : dbdrs_sequencer

/* File: tb/dbdrs_props.sv */
// Port checks of the diagnostic reset sequencer.
module dbdrs_props #(
    parameter logic [1:0] LANE = 2'h0
) (
    // Clock, reset and master lines.
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic selectOut,
    input wire logic masterOut,
    input wire logic syncOut,
    input wire logic [7:0] busAOut,
    // Slave outputs.
    input wire logic driversEnable,
    input wire logic diagReset,
    input wire logic diagBusy
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [2:0] D = (LANE == 2'h0) ? 3'h1 : ((LANE == 2'h1) ? 3'h4 : 3'h7);
    logic on, ent, sel;
    assign on = busAOut[D] && busAOut[D - 3'h1];
    assign ent = !selectOut && !masterOut && syncOut;
    assign sel = !selectOut && masterOut && syncOut;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_entry_release: assert property (
        ent[*6] |-> !driversEnable) else $error("drivers kept");
    a_active_quiet: assert property (
        driversEnable |-> !diagBusy && !diagReset) else $error("active busy");
    a_strobe_reset: assert property (
        !driversEnable && $fell(syncOut) && on ##1 on[*5] |-> diagReset) else $error("no reset");
    a_data_release: assert property (
        diagReset && !on ##1 !on[*5] |-> !diagReset) else $error("reset kept");
    a_reset_drv: assert property (
        diagReset |-> !driversEnable && diagBusy) else $error("driving in reset");
    a_drv_hold: assert property (
        (!sel)[*7] ##0 !driversEnable |=> !driversEnable) else $error("early drive");
    a_sel_enable: assert property (
        (sel && !on)[*6] |-> driversEnable && !diagBusy) else $error("not driving");
endmodule : dbdrs_props
bind dbdrs_sequencer dbdrs_props #(.LANE(LANE)) i_props (.clk_sys, .reset, .selectOut,
    .masterOut, .syncOut, .busAOut, .driversEnable, .diagReset, .diagBusy);

/* File: tb/dbdrs_master_model.sv */
// Behavioural bus master for the diagnostic sequence.
module dbdrs_master_model (
    // Clock.
    input wire logic clk_sys,
    // Control lines and bus A.
    output logic selectOut,
    output logic masterOut,
    output logic syncOut,
    output logic [7:0] busAOut
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {selectOut, masterOut, syncOut, busAOut} = 11'h000;
    // Each level is held eight cycles, so the slave filter and registers settle before the checks.
    task automatic drive(input logic [2:0] ctl, input logic [7:0] bus);
        @(posedge clk_sys);
        #2;
        {selectOut, masterOut, syncOut} = ctl;
        busAOut = bus;
        repeat (8) @(posedge clk_sys);
        #1;
    endtask : drive
endmodule : dbdrs_master_model

/* File: tb/tb.sv */
// Self-checking bench of the diagnostic reset sequencer.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic selectOut, masterOut, syncOut, driversEnable, diagReset, diagBusy;
    logic driversEnable2, diagReset2, diagBusy2;
    logic [7:0] busAOut;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    initial forever #12.5 clk_sys = ~clk_sys;
    dbdrs_master_model i_master (.clk_sys, .selectOut, .masterOut, .syncOut, .busAOut);
    dbdrs_sequencer #(.LANE(2'h0)) i_dut (.clk_sys, .reset, .selectOut, .masterOut,
        .syncOut, .busAOut, .driversEnable, .diagReset, .diagBusy);
    // A second slave on lane 2 proves that lane 0 data alone does not reset it.
    dbdrs_sequencer #(.LANE(2'h2)) i_dut_lane2 (.clk_sys, .reset, .selectOut, .masterOut,
        .syncOut, .busAOut, .driversEnable(driversEnable2), .diagReset(diagReset2),
        .diagBusy(diagBusy2));
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", what, exp, seen);
        end
    endtask : chk
    task automatic t_reset(input int n);
        @(posedge clk_sys);
        #2;
        reset = 1'b1;
        repeat (n) @(posedge clk_sys);
        #2;
        reset = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("driversEnable", driversEnable, 1'b1);
        chk("diagReset", diagReset, 1'b0);
        chk("diagBusy", diagBusy, 1'b0);
        $display("t_reset done");
    endtask : t_reset
    // Lines are {select, master, strobe}; lane 0 data is bit 1, its enable bit 0.
    task automatic t_mm1();
        i_master.drive(3'h1, 8'h00);
        chk("driversEnable", driversEnable, 1'b0);
        chk("diagBusy", diagBusy, 1'b1);
        i_master.drive(3'h1, 8'h03);
        chk("diagReset", diagReset, 1'b0);
        i_master.drive(3'h0, 8'h03);
        chk("diagReset", diagReset, 1'b1);
        i_master.drive(3'h0, 8'h00);
        chk("diagReset", diagReset, 1'b0);
        i_master.drive(3'h4, 8'h00);
        chk("driversEnable", driversEnable, 1'b0);
        i_master.drive(3'h3, 8'h00);
        chk("driversEnable", driversEnable, 1'b1);
        chk("diagBusy", diagBusy, 1'b0);
        $display("t_mm1 done");
    endtask : t_mm1
    task automatic t_refuse();
        i_master.drive(3'h5, 8'h03);
        i_master.drive(3'h4, 8'h03);
        chk("diagReset", diagReset, 1'b0);
        i_master.drive(3'h1, 8'h1A);
        i_master.drive(3'h0, 8'h1A);
        chk("diagReset", diagReset, 1'b0);
        i_master.drive(3'h1, 8'h03);
        i_master.drive(3'h0, 8'h03);
        chk("diagReset", diagReset, 1'b1);
        chk("diagReset2", diagReset2, 1'b0);
        chk("diagBusy2", diagBusy2, 1'b1);
        i_master.drive(3'h0, 8'h02);
        chk("diagReset", diagReset, 1'b0);
        chk("driversEnable", driversEnable, 1'b0);
        $display("t_refuse done");
    endtask : t_refuse
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 1000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        t_reset(8);
        t_mm1();
        t_refuse();
        t_reset(2);
        print_verdict();
    end
endmodule : tb
